// *** sdwl_loader.sv ***
// serial dac word loader: shift register, input latch and dac register
`timescale 1ns/1ps
// What this block does
// - dac register clears to zero at reset, holds until a transfer
// - shift register is not cleared by reset
// - more than 14 bits shifted: only last 14 kept
// - fewer than 14 bits: older bits stay and are transferred
// - data sampled on each rising serial clock edge within a frame into 14-bit word
// - dac register updated at frame end or by load strobe
// - msb sent first; first retained bit is msb
// - frame select rising loads the new word
// - unipolar code is straight binary
// - bipolar code is offset binary
// - bits accepted only while frame select is low
// - strobe tied low: frame select rising updates dac register
module sdwl_loader #(
    parameter int WORD_W = sdwl_pkg::WORD_W
) (
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic FRAME_SEL_N_I,
    input wire logic SERIAL_CLK_I,
    input wire logic SERIAL_DATA_LINE_I,
    input wire logic DAC_LOAD_STROBE_N_I,
    input wire logic BIPOLAR_I,
    output logic [WORD_W-1:0] DAC_CODE_O,
    output logic [WORD_W-1:0] DAC_SIGNED_O,
    output logic DAC_UPDATE_O,
    output logic FRAME_ACTIVE_O
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    sdwl_pkg::sdwl_pins_s pins_raw;
    sdwl_pkg::sdwl_pins_s meta_r;
    sdwl_pkg::sdwl_pins_s sync_r;
    sdwl_pkg::sdwl_pins_s prev_r;

    assign pins_raw = '{frame_sel_n: FRAME_SEL_N_I, serial_clk: SERIAL_CLK_I,
                        serial_data_line: SERIAL_DATA_LINE_I,
                        dac_load_strobe_n: DAC_LOAD_STROBE_N_I};

    // pins come from the host domain; idle values (select and strobe high, clock and data low) avoid false edges out of reset
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            meta_r <= sdwl_pkg::PINS_IDLE;
            sync_r <= sdwl_pkg::PINS_IDLE;
            prev_r <= sdwl_pkg::PINS_IDLE;
        end else begin
            meta_r <= pins_raw;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // ------------------------------------------------------------
    // edge decode
    // ------------------------------------------------------------
    wire sclk_rise;
    wire frame_low;
    wire frame_end;
    wire strobe_low;
    wire shift_en;

    assign sclk_rise = sync_r.serial_clk & ~prev_r.serial_clk;
    assign frame_low = ~sync_r.frame_sel_n;
    assign frame_end = sync_r.frame_sel_n & ~prev_r.frame_sel_n;
    assign strobe_low = ~sync_r.dac_load_strobe_n;
    // clock edges while deselected are ignored, so idle bursts cannot corrupt the word
    assign shift_en = sclk_rise & frame_low & ~prev_r.frame_sel_n;

    // ------------------------------------------------------------
    // shift register, not reset by design
    // ------------------------------------------------------------
    logic [WORD_W-1:0] shift_r;
    logic [WORD_W-1:0] shift_nxt;

    // msb first: older bits move up, last 14 remain, short frames keep old bits
    assign shift_nxt = {shift_r[WORD_W-2:0], sync_r.serial_data_line};

    // no reset branch: contents stay undefined until data arrives
    always_ff @(posedge CORE_CLK_I) begin
        if (shift_en) begin
            shift_r <= shift_nxt;
        end
    end

    // ------------------------------------------------------------
    // fill tracking for the checks
    // ------------------------------------------------------------
    // counts bits shifted since reset, saturating at one word; the shift
    // register itself stays unreset, so checks on its contents wait for this
    localparam int FILL_W = $clog2(WORD_W + 1);
    localparam logic [FILL_W-1:0] FILL_FULL = FILL_W'(WORD_W);
    logic [FILL_W-1:0] fill_r;
    logic [FILL_W-1:0] fill_nxt;
    wire word_filled;

    // saturate rather than wrap, so a long stream never closes the gate again
    assign fill_nxt = (shift_en && (fill_r != FILL_FULL)) ? fill_r + 1'b1 : fill_r;
    assign word_filled = (fill_r == FILL_FULL);

    // reset clears only the count, never the shift register
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            fill_r <= '0;
        end else begin
            fill_r <= fill_nxt;
        end
    end

    // ------------------------------------------------------------
    // input latch and dac register
    // ------------------------------------------------------------
    sdwl_pkg::sdwl_state_e state_r;
    sdwl_pkg::sdwl_state_e state_nxt;
    logic pend_r;
    logic pend_nxt;
    logic [WORD_W-1:0] latch_r;
    logic [WORD_W-1:0] latch_nxt;
    logic [WORD_W-1:0] dac_r;
    logic [WORD_W-1:0] dac_nxt;
    wire load_now;
    wire [WORD_W-1:0] load_word;

    assign state_nxt = frame_low ? sdwl_pkg::ST_SHIFT : sdwl_pkg::ST_IDLE;
    // frame end with strobe low loads at once; a strobe high holds the word
    assign load_now = (frame_end & strobe_low) | (pend_r & strobe_low);
    assign load_word = frame_end ? shift_r : latch_r;
    assign latch_nxt = frame_end ? shift_r : latch_r;
    assign pend_nxt = frame_end ? ~strobe_low : (pend_r & ~strobe_low);
    assign dac_nxt = load_now ? load_word : dac_r;

    // dac register clears at reset and only moves on a load
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_r <= sdwl_pkg::ST_IDLE;
            pend_r <= 1'b0;
            latch_r <= sdwl_pkg::DAC_RST_VAL;
            dac_r <= sdwl_pkg::DAC_RST_VAL;
        end else begin
            state_r <= state_nxt;
            pend_r <= pend_nxt;
            latch_r <= latch_nxt;
            dac_r <= dac_nxt;
        end
    end

    // ------------------------------------------------------------
    // code views
    // ------------------------------------------------------------
    // bipolar view flips the msb: offset binary becomes two's complement,
    // so midscale reads as zero; unipolar passes the code straight through
    function automatic logic [WORD_W-1:0] code_view(input logic [WORD_W-1:0] code,
                                                    input logic bip);
        logic [WORD_W-1:0] offs;
        offs = '0;
        offs[WORD_W-1] = 1'b1;
        return bip ? (code ^ offs) : code;
    endfunction : code_view

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // straight binary for unipolar; msb flipped gives a two's-complement view in bipolar
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            DAC_CODE_O <= sdwl_pkg::DAC_RST_VAL;
            DAC_SIGNED_O <= sdwl_pkg::DAC_RST_VAL ^ sdwl_pkg::BIPOLAR_ZERO;
            DAC_UPDATE_O <= 1'b0;
            FRAME_ACTIVE_O <= 1'b0;
        end else begin
            DAC_CODE_O <= dac_nxt;
            DAC_SIGNED_O <= code_view(dac_nxt, BIPOLAR_I);
            DAC_UPDATE_O <= load_now;
            FRAME_ACTIVE_O <= (state_nxt == sdwl_pkg::ST_SHIFT);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    dac_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        !load_now |=> DAC_CODE_O == $past(DAC_CODE_O))
        else $error("dac code moved without a load");
    frame_load_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        frame_end && strobe_low |=> DAC_CODE_O == $past(shift_r))
        else $error("frame end did not load the shift word");
    shift_gate_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        sync_r.frame_sel_n && word_filled |=> shift_r == $past(shift_r))
        else $error("shift register moved while deselected");
    shift_msb_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        shift_en |=> shift_r[0] == $past(sync_r.serial_data_line))
        else $error("new bit not in lsb");
    strobe_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        frame_end && !strobe_low |=> DAC_CODE_O == $past(DAC_CODE_O) && pend_r)
        else $error("word not held while strobe high");
    strobe_load_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        pend_r && strobe_low && !frame_end |=> DAC_CODE_O == $past(latch_r) && DAC_UPDATE_O)
        else $error("strobe did not load latched word");
    bipolar_map_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        ##1 $past(BIPOLAR_I) |-> DAC_SIGNED_O[WORD_W-1] != DAC_CODE_O[WORD_W-1])
        else $error("bipolar msb not offset");
    unipolar_map_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        ##1 !$past(BIPOLAR_I) |-> DAC_SIGNED_O == DAC_CODE_O)
        else $error("unipolar code not straight binary");

    // ------------------------------------------------------------
    // update pulse and dac register
    // ------------------------------------------------------------
    // the code may only move in the cycle that reports an update
    upd_quiet_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        !DAC_UPDATE_O |-> DAC_CODE_O == $past(DAC_CODE_O))
        else $error("dac code changed with no update pulse");

    // one load gives one pulse, never a run of them
    upd_single_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        DAC_UPDATE_O |=> !DAC_UPDATE_O)
        else $error("update pulse longer than one cycle");

    // a low strobe with nothing pending and no frame end must not load anything
    strobe_idle_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        !pend_r && !frame_end |=> !DAC_UPDATE_O)
        else $error("update without frame end or pending word");

    // the loaded word is always the fresh or latched one
    upd_word_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        load_now |=> DAC_CODE_O == $past(load_word) && DAC_UPDATE_O)
        else $error("load did not deliver the selected word");

    // ------------------------------------------------------------
    // input latch and pending flag
    // ------------------------------------------------------------
    // once the strobe falls the pending word is consumed
    pend_clear_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        pend_r && strobe_low |=> !pend_r)
        else $error("pending flag survived a strobe");

    // pending stays while the strobe stays high
    pend_keep_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        pend_r && !strobe_low |=> pend_r)
        else $error("pending word dropped with strobe high");

    // latch only moves at frame end
    latch_keep_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        !frame_end && word_filled |=> latch_r == $past(latch_r))
        else $error("input latch moved outside frame end");

    // frame end captures the complete shift word
    latch_take_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        frame_end && word_filled |=> latch_r == $past(shift_r))
        else $error("input latch missed the shift word");

    // ------------------------------------------------------------
    // shift register and frame
    // ------------------------------------------------------------
    // each accepted bit moves the older bits up one place
    shift_move_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        shift_en && word_filled |=>
            shift_r[WORD_W-1:1] == $past(shift_r[WORD_W-2:0]))
        else $error("older bits not moved towards msb");

    // the bit counter never passes one word
    fill_bound_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        fill_r <= FILL_FULL)
        else $error("fill count out of range");

    // the frame flag follows the registered state
    active_state_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        FRAME_ACTIVE_O == (state_r == sdwl_pkg::ST_SHIFT))
        else $error("frame flag disagrees with state");

    // state codes stay one-hot
    state_onehot_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        $onehot(state_r))
        else $error("state not one-hot");

    // frame flag reflects the synchronised select of the previous cycle
    active_track_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        ##1 1'b1 |-> FRAME_ACTIVE_O == $past(frame_low))
        else $error("frame flag lags the select");

    // signed view is the full code view, not only the msb
    bipolar_full_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
        ##1 1'b1 |-> DAC_SIGNED_O == code_view(DAC_CODE_O, $past(BIPOLAR_I)))
        else $error("signed view does not match code");
endmodule : sdwl_loader

// *** sdwl_pkg.sv ***
// package of constants and types for the serial dac word loader
package sdwl_pkg;
    // ------------------------------------------------------------
    // word format
    // ------------------------------------------------------------
    localparam int WORD_W = 14;
    localparam logic [13:0] DAC_RST_VAL = 14'h0000;
    localparam logic [13:0] BIPOLAR_ZERO = 14'h2000;
    localparam logic [13:0] FULL_SCALE = 14'h3FFF;
    // pin idle levels out of reset: frame select high, clock low, data low, strobe high
    localparam logic [3:0] PINS_IDLE = 4'h9;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic frame_sel_n;
        logic serial_clk;
        logic serial_data_line;
        logic dac_load_strobe_n;
    } sdwl_pins_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } sdwl_state_e;
endpackage : sdwl_pkg

// *** sdwl_host_model.sv ***
// host serial master model driving the loader pins
`timescale 1ns/1ps
module sdwl_host_model (
    input wire logic clk_i,
    output logic sel_n_o,
    output logic sclk_o,
    output logic sdata_o,
    output logic ld_n_o
);
    // --------------------------------------------------------------
    // idle pins: no frame, clock parked low
    // --------------------------------------------------------------
    initial begin
        sel_n_o = 1'h1;
        sclk_o = 1'h0;
        sdata_o = 1'h0;
        ld_n_o = 1'h0;
    end

    // shift n bits msb first; on=0 clocks with frame select left high
    task automatic send(input logic [15:0] w, input int n, input logic on);
        int i;
        @(posedge clk_i) sel_n_o <= ~on;
        for (i = n - 1; i >= 0; i--) begin
            sclk_o <= 1'h0;
            sdata_o <= w[i];
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'h1;
            repeat (4) @(posedge clk_i);
        end
        // clock stops between frames, data no longer holds its value
        sclk_o <= 1'h0;
        sdata_o <= ~sdata_o;
        repeat (4) @(posedge clk_i);
        sel_n_o <= 1'h1;
    endtask : send

    // strobe idles low so frames load at once; set_ld drives it to v on the next clock
    task automatic set_ld(input logic v);
        @(posedge clk_i) ld_n_o <= v;
    endtask : set_ld
endmodule : sdwl_host_model

// *** sdwl_loader_tb_top.sv ***
// self-checking bench for the serial dac word loader
`timescale 1ns/1ps
module sdwl_loader_tb_top;
    logic clk;
    logic rstn;
    logic bip;
    logic sel_n, sclk, sdata, ld_n;
    logic [13:0] code, signed_code;
    logic upd, act;
    int bad_count = 0;
    int check_count = 0;

    sdwl_host_model host (.clk_i(clk), .sel_n_o(sel_n), .sclk_o(sclk), .sdata_o(sdata),
        .ld_n_o(ld_n));
    sdwl_loader DUT (.CORE_CLK_I(clk), .RSTN_I(rstn), .FRAME_SEL_N_I(sel_n),
        .SERIAL_CLK_I(sclk), .SERIAL_DATA_LINE_I(sdata), .DAC_LOAD_STROBE_N_I(ld_n),
        .BIPOLAR_I(bip), .DAC_CODE_O(code), .DAC_SIGNED_O(signed_code),
        .DAC_UPDATE_O(upd), .FRAME_ACTIVE_O(act));

    // --------------------------------------------------------------
    // checking helpers
    // --------------------------------------------------------------
    task automatic cmp(input logic [13:0] a, input logic [13:0] e);
        check_count++;
        if (a !== e) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e);
            bad_count++;
        end
    endtask : cmp

    // watch a fixed window for the one-cycle update pulse, then the code
    task automatic expect_upd(input logic want, input logic [13:0] e);
        logic seen;
        seen = 1'h0;
        repeat (40) begin
            @(posedge clk);
            #1;
            if (upd === 1'h1) seen = 1'h1;
        end
        cmp({13'h0000, seen}, {13'h0000, want});
        cmp({13'h0000, act}, 14'h0000);
        cmp(code, e);
        cmp(signed_code, bip ? e ^ sdwl_pkg::BIPOLAR_ZERO : e);
    endtask : expect_upd

    task automatic final_report();
        if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_full();
        fork
            host.send(16'h2A5C, 14, 1'h1);
            begin
                repeat (8) @(posedge clk);
                #1;
                cmp({13'h0000, act}, 14'h0001);
            end
        join
        expect_upd(1'h1, 14'h2A5C);
    endtask : t_full

    task automatic t_long();
        host.send(16'hC123, 16, 1'h1);
        expect_upd(1'h1, 14'h0123);
    endtask : t_long

    task automatic t_short();
        host.send(16'h00A5, 8, 1'h1);
        expect_upd(1'h1, 14'h23A5);
    endtask : t_short

    // clocks with frame high must not shift: next nibble lands on old bits
    task automatic t_ignore();
        host.send(16'h3FFF, 14, 1'h0);
        expect_upd(1'h0, 14'h23A5);
        host.send(16'h0000, 4, 1'h1);
        expect_upd(1'h1, 14'h3A50);
    endtask : t_ignore

    // strobe high: word waits until the strobe falls
    task automatic t_strobe();
        host.set_ld(1'h1);
        host.send(16'h1555, 14, 1'h1);
        expect_upd(1'h0, 14'h3A50);
        host.set_ld(1'h0);
        expect_upd(1'h1, 14'h1555);
    endtask : t_strobe

    // mid-run reset clears the dac register; shift bits survive it
    task automatic t_reset();
        @(posedge clk) rstn <= 1'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        repeat (4) @(posedge clk);
        #1;
        cmp(code, sdwl_pkg::DAC_RST_VAL);
        cmp({13'h0000, upd}, 14'h0000);
        host.send(16'h0003, 2, 1'h1);
        expect_upd(1'h1, 14'h1557);
    endtask : t_reset

    // --------------------------------------------------------------
    // clock, reset, sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    initial begin
        rstn = 1'h0;
        bip = 1'h0;
        repeat (16) @(posedge clk);
        rstn <= 1'h1;
        repeat (4) @(posedge clk);
        #1;
        cmp(code, sdwl_pkg::DAC_RST_VAL);
        t_full();
        @(posedge clk) bip <= 1'h1;
        t_long();
        t_short();
        @(posedge clk) bip <= 1'h0;
        t_ignore();
        t_strobe();
        t_reset();
        final_report();
    end

    // sequence needs about 960 cycles; allow ample margin
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        final_report();
    end
endmodule : sdwl_loader_tb_top
